// ==== core/pdc_map.svh ====
// Register offsets, field positions, reset values and masks of the
// dead-time and carrier stage. Assumes word-aligned AXI4-Lite access.
// Function
// - Two-bit B action: keep, low, high, toggle
// - B action per event and count direction
// - Dead-time clock: module clock or timer clock
// - Dual-edge B puts both delays on B
// - Rising delay loads per four-bit method
// - Falling delay loads per four-bit method
// - Falling delay write reaches shadow only
// - Rising delay write reaches shadow only
// - Carrier input invert flips A and B
// - Carrier output invert flips A and B
// - First burst pulse ends at the width-th carrier period end
// - Carrier period is eight clocks times prescale plus one
// - Carrier enable modulates, else pass through
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH

`define PDC_STATUS_OFS   12'h0c0
`define PDC_GEN_B_OFS    12'h0c4
`define PDC_DT_CFG_OFS   12'h0c8
`define PDC_FED_OFS      12'h0cc
`define PDC_RED_OFS      12'h0d0
`define PDC_CAR_OFS      12'h0d4

`define PDC_GEN_B_RST    32'h0000_0000
`define PDC_DT_CFG_RST   32'h0001_8000
`define PDC_DLY_RST      32'h0000_0000
`define PDC_CAR_RST      32'h0000_0000

`define PDC_GEN_B_MASK   32'h00ff_ffff
`define PDC_DT_CFG_MASK  32'h0003_ffff
`define PDC_DLY_MASK     32'h0000_ffff
`define PDC_CAR_MASK     32'h0000_3fff

`define PDC_GEN_DOWN     12
`define PDC_DT_FED_UPM   0
`define PDC_DT_RED_UPM   4
`define PDC_DT_DEB       8
`define PDC_DT_A_SWAP    9
`define PDC_DT_B_SWAP    10
`define PDC_DT_RED_INSEL 11
`define PDC_DT_FED_INSEL 12
`define PDC_DT_RED_OINV  13
`define PDC_DT_FED_OINV  14
`define PDC_DT_A_BYP     15
`define PDC_DT_B_BYP     16
`define PDC_DT_CLK_SEL   17
`define PDC_CAR_LSB      0
`define PDC_CAR_W        14
`define PDC_CAR_PHASES   3'h7

`define PDC_RESP_OKAY    2'h0
`define PDC_RESP_SLVERR  2'h2

`endif

// ==== core/pdc_pkg.sv ====
// Types shared by the dead-time and carrier stage.
// Assumes the layouts in pdc_map.svh match the struct field order.
package pdc_pkg;

	typedef struct packed {
		logic       in_invert;
		logic       out_invert;
		logic [3:0] first_pulse_width;
		logic [2:0] duty;
		logic [3:0] prescale;
		logic       enable;
	} pdc_car_cfg_s;

	typedef enum logic [1:0] {
		PDC_IDLE = 2'h0,
		PDC_SHOT = 2'h1,
		PDC_RUN  = 2'h3
	} pdc_car_st_e;

	typedef logic [1:0] pdc_action_t;

endpackage

// ==== core/pdc_carrier.sv ====
// Carrier modulator for the A and B outputs.
// Assumes inputs come from logic on aclk; outputs are registered.
`timescale 1ns/10ps
`include "pdc_map.svh"

module pdc_carrier (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire pdc_pkg::pdc_car_cfg_s cfg,
	input  wire logic [1:0]            sig_in,
	output logic      [1:0]            sig_out
);

	logic [3:0] pre_q;
	logic [3:0] pre_d;
	logic [2:0] phase_q;
	logic [2:0] phase_d;
	logic       tick;
	logic       period_end;
	logic       carrier;

	always_comb begin
		tick       = (pre_q == cfg.prescale);
		pre_d      = tick ? 4'h0 : pre_q + 4'h1;
		phase_d    = tick ? phase_q + 3'h1 : phase_q;
		period_end = tick && (phase_q == `PDC_CAR_PHASES);
		// High phases end the period, so a one-shot never merges into one
		carrier    = ({1'b0, phase_q} + {1'b0, cfg.duty}) >= 4'h8;
		if (!cfg.enable) begin
			pre_d   = 4'h0;
			phase_d = 3'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_q   <= 4'h0;
			phase_q <= 3'h0;
		end else begin
			pre_q   <= pre_d;
			phase_q <= phase_d;
		end
	end

	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_ch
			pdc_pkg::pdc_car_st_e st_q;
			pdc_pkg::pdc_car_st_e st_d;
			logic [3:0]           cnt_q;
			logic [3:0]           cnt_d;
			logic                 in_x;
			logic                 mod;
			logic                 out_d;
			logic                 out_q;

			always_comb begin
				in_x  = sig_in[c] ^ cfg.in_invert;
				st_d  = st_q;
				cnt_d = cnt_q;
				case (st_q)
				pdc_pkg::PDC_IDLE: begin
					cnt_d = 4'h0;
					if (in_x)
						st_d = (cfg.first_pulse_width != 4'h0) ?
							pdc_pkg::PDC_SHOT : pdc_pkg::PDC_RUN;
				end
				pdc_pkg::PDC_SHOT: begin
					if (!in_x) begin
						st_d = pdc_pkg::PDC_IDLE;
					end else if (period_end) begin
						cnt_d = cnt_q + 4'h1;
						if (cnt_d == cfg.first_pulse_width)
							st_d = pdc_pkg::PDC_RUN;
					end
				end
				pdc_pkg::PDC_RUN: begin
					if (!in_x)
						st_d = pdc_pkg::PDC_IDLE;
				end
				default: st_d = pdc_pkg::PDC_IDLE;
				endcase
				if (!cfg.enable)
					st_d = pdc_pkg::PDC_IDLE;
				mod = (st_q == pdc_pkg::PDC_SHOT) ||
					((st_q == pdc_pkg::PDC_RUN) && in_x && carrier);
				// Disabled carrier passes the level straight on
				out_d = (cfg.enable ? mod : in_x)
					^ cfg.out_invert;
			end

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					st_q  <= pdc_pkg::PDC_IDLE;
					cnt_q <= 4'h0;
					out_q <= 1'b0;
				end else begin
					st_q  <= st_d;
					cnt_q <= cnt_d;
					out_q <= out_d;
				end
			end

			assign sig_out[c] = out_q;
		end
	endgenerate

endmodule

// ==== core/pdc_stage.sv ====
// Output B action table, dead-time generator and carrier stage with an
// AXI4-Lite register slave. Assumes events and operator_out_a come from
// logic on aclk, and timer_clock arrives from outside this domain.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "pdc_map.svh"

module pdc_stage (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        counter_zero_event,
	input  wire logic        counter_period_event,
	input  wire logic        compare_a_event,
	input  wire logic        compare_b_event,
	input  wire logic        trigger0_event,
	input  wire logic        trigger1_event,
	input  wire logic        count_down,
	input  wire logic        sync_event,
	input  wire logic        timer_clock,
	input  wire logic        operator_out_a,
	output logic             stage_out_a,
	output logic             stage_out_b
);

	logic [31:0] gen_b_q;
	logic [31:0] gen_b_d;
	logic [31:0] dt_cfg_q;
	logic [31:0] dt_cfg_d;
	logic [31:0] fed_sh_q;
	logic [31:0] fed_sh_d;
	logic [31:0] red_sh_q;
	logic [31:0] red_sh_d;
	logic [31:0] car_q;
	logic [31:0] car_d;
	logic [11:0] awaddr_q;
	logic [11:0] awaddr_d;
	logic [31:0] wdata_q;
	logic [31:0] wdata_d;
	logic [3:0]  wstrb_q;
	logic [3:0]  wstrb_d;
	logic        aw_full_q;
	logic        aw_full_d;
	logic        w_full_q;
	logic        w_full_d;
	logic        awready_q;
	logic        awready_d;
	logic        wready_q;
	logic        wready_d;
	logic        bvalid_q;
	logic        bvalid_d;
	logic [1:0]  bresp_q;
	logic [1:0]  bresp_d;
	logic        arready_q;
	logic        arready_d;
	logic        rvalid_q;
	logic        rvalid_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0]  rresp_q;
	logic [1:0]  rresp_d;
	logic        do_write;
	logic [15:0] act_dly [2];

	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				res[8*i +: 8] = new_v[8*i +: 8];
		end
		return res;
	endfunction

	// Write path: address and data are held until both have arrived
	always_comb begin
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		aw_full_d = aw_full_q;
		w_full_d  = w_full_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		gen_b_d   = gen_b_q;
		dt_cfg_d  = dt_cfg_q;
		fed_sh_d  = fed_sh_q;
		red_sh_d  = red_sh_q;
		car_d     = car_q;
		do_write  = aw_full_q && w_full_q && !bvalid_q;
		if (s_axi_awvalid && awready_q) begin
			awaddr_d  = s_axi_awaddr;
			aw_full_d = 1'b1;
		end
		if (s_axi_wvalid && wready_q) begin
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
			w_full_d = 1'b1;
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		if (do_write) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = `PDC_RESP_OKAY;
			case ({awaddr_q[11:2], 2'h0})
			`PDC_GEN_B_OFS: gen_b_d = merge_bytes(gen_b_q, wdata_q,
				wstrb_q) & `PDC_GEN_B_MASK;
			`PDC_DT_CFG_OFS: dt_cfg_d = merge_bytes(dt_cfg_q, wdata_q,
				wstrb_q) & `PDC_DT_CFG_MASK;
			`PDC_FED_OFS: fed_sh_d = merge_bytes(fed_sh_q, wdata_q,
				wstrb_q) & `PDC_DLY_MASK;
			`PDC_RED_OFS: red_sh_d = merge_bytes(red_sh_q, wdata_q,
				wstrb_q) & `PDC_DLY_MASK;
			`PDC_CAR_OFS: car_d = merge_bytes(car_q, wdata_q,
				wstrb_q) & `PDC_CAR_MASK;
			`PDC_STATUS_OFS: bresp_d = `PDC_RESP_OKAY;
			default: bresp_d = `PDC_RESP_SLVERR;
			endcase
		end
		awready_d = !aw_full_d && !bvalid_d;
		wready_d  = !w_full_d && !bvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_q  <= 12'h000;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `PDC_RESP_OKAY;
			gen_b_q   <= `PDC_GEN_B_RST;
			dt_cfg_q  <= `PDC_DT_CFG_RST;
			fed_sh_q  <= `PDC_DLY_RST;
			red_sh_q  <= `PDC_DLY_RST;
			car_q     <= `PDC_CAR_RST;
		end else begin
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			gen_b_q   <= gen_b_d;
			dt_cfg_q  <= dt_cfg_d;
			fed_sh_q  <= fed_sh_d;
			red_sh_q  <= red_sh_d;
			car_q     <= car_d;
		end
	end

	// Read path: one read in flight, answered the cycle after address
	always_comb begin
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d  = `PDC_RESP_OKAY;
			case ({s_axi_araddr[11:2], 2'h0})
			`PDC_STATUS_OFS: rdata_d = {act_dly[1], act_dly[0]};
			`PDC_GEN_B_OFS:  rdata_d = gen_b_q;
			`PDC_DT_CFG_OFS: rdata_d = dt_cfg_q;
			`PDC_FED_OFS:    rdata_d = fed_sh_q;
			`PDC_RED_OFS:    rdata_d = red_sh_q;
			`PDC_CAR_OFS:    rdata_d = car_q;
			default: begin
				rdata_d = 32'h0000_0000;
				rresp_d = `PDC_RESP_SLVERR;
			end
			endcase
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= `PDC_RESP_OKAY;
		end else begin
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	// Output B action table; later events in the list win a tie
	logic [5:0] events;
	logic       out_b_q;
	logic       out_b_d;

	always_comb begin
		pdc_pkg::pdc_action_t act;
		act     = 2'h0;
		events  = {trigger1_event, trigger0_event, compare_b_event,
			compare_a_event, counter_period_event, counter_zero_event};
		out_b_d = out_b_q;
		for (int i = 0; i < 6; i++) begin
			act = count_down ? gen_b_q[`PDC_GEN_DOWN + 2*i +: 2]
				: gen_b_q[2*i +: 2];
			if (events[i]) begin
				case (act)
				2'h1:    out_b_d = 1'b0;
				2'h2:    out_b_d = 1'b1;
				2'h3:    out_b_d = ~out_b_q;
				default: out_b_d = out_b_d;
				endcase
			end
		end
	end

	// Timer clock is foreign: two flops, then edge detect on the second
	logic tclk_s1_q;
	logic tclk_s2_q;
	logic tclk_s3_q;
	logic dt_tick;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_b_q   <= 1'b0;
			tclk_s1_q <= 1'b0;
			tclk_s2_q <= 1'b0;
			tclk_s3_q <= 1'b0;
		end else begin
			out_b_q   <= out_b_d;
			tclk_s1_q <= timer_clock;
			tclk_s2_q <= tclk_s1_q;
			tclk_s3_q <= tclk_s2_q;
		end
	end

	assign dt_tick = dt_cfg_q[`PDC_DT_CLK_SEL] ?
		(tclk_s2_q && !tclk_s3_q) : 1'b1;

	// Swap first, so delay paths and bypass both see swapped signals
	logic a_sw;
	logic b_sw;
	logic [1:0] path;

	assign a_sw = dt_cfg_q[`PDC_DT_A_SWAP] ? out_b_q : operator_out_a;
	assign b_sw = dt_cfg_q[`PDC_DT_B_SWAP] ? operator_out_a : out_b_q;

	// Index 0 is the rising-edge delay, index 1 the falling-edge delay
	genvar k;
	generate
		for (k = 0; k < 2; k++) begin : g_dly
			logic [15:0] act_q;
			logic [15:0] act_d;
			logic [15:0] cnt_q;
			logic [15:0] cnt_d;
			logic        hit_q;
			logic        hit_d;
			logic [3:0]  upm;
			logic        load;
			logic        lvl;

			always_comb begin
				upm = k ? dt_cfg_q[`PDC_DT_FED_UPM +: 4]
					: dt_cfg_q[`PDC_DT_RED_UPM +: 4];
				// Bit 3 blocks every update, zero tracks the shadow
				load = !upm[3] && ((upm == 4'h0) ||
					(upm[0] && counter_zero_event) ||
					(upm[1] && counter_period_event) ||
					(upm[2] && sync_event));
				act_d = load ? (k ? fed_sh_q[15:0] : red_sh_q[15:0])
					: act_q;
				lvl = (dt_cfg_q[k ? `PDC_DT_FED_INSEL
					: `PDC_DT_RED_INSEL] ? b_sw : a_sw) ^ (k != 0);
				cnt_d = cnt_q;
				hit_d = hit_q;
				if (!lvl) begin
					cnt_d = 16'h0000;
					hit_d = 1'b0;
				end else if (cnt_q >= act_q) begin
					hit_d = 1'b1;
				end else if (dt_tick) begin
					cnt_d = cnt_q + 16'h0001;
				end
			end

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					act_q <= 16'h0000;
					cnt_q <= 16'h0000;
					hit_q <= 1'b0;
				end else begin
					act_q <= act_d;
					cnt_q <= cnt_d;
					hit_q <= hit_d;
				end
			end

			assign act_dly[k] = act_q;
			assign path[k] = (hit_q ^ (k != 0)) ^ dt_cfg_q[k ?
				`PDC_DT_FED_OINV : `PDC_DT_RED_OINV];
		end
	endgenerate

	logic [1:0] dt_out;

	always_comb begin
		if (dt_cfg_q[`PDC_DT_DEB]) begin
			dt_out[0] = a_sw;
			dt_out[1] = path[0] & path[1];
		end else begin
			dt_out[0] = path[0];
			dt_out[1] = path[1];
		end
		if (dt_cfg_q[`PDC_DT_A_BYP])
			dt_out[0] = a_sw;
		if (dt_cfg_q[`PDC_DT_B_BYP])
			dt_out[1] = b_sw;
	end

	logic [1:0] car_out;

	pdc_carrier u_carrier (
		.aclk    (aclk),
		.aresetn (aresetn),
		.cfg     (pdc_pkg::pdc_car_cfg_s'(car_q[`PDC_CAR_LSB +: `PDC_CAR_W])),
		.sig_in  (dt_out),
		.sig_out (car_out)
	);

	assign stage_out_a   = car_out[0];
	assign stage_out_b   = car_out[1];
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

endmodule

// ==== tb/pdc_gate_model.sv ====
// Gate driver stand-in that watches one stage output pin.
// Assumes pin is settled at each rising edge of aclk.
`timescale 1ns/10ps
module pdc_gate_model (
	input  wire logic        aclk,
	input  wire logic        pin,
	input  wire logic        clr,
	output logic      [15:0] period,
	output logic      [15:0] first_hi
);
	logic        last_q;
	logic        done_q;
	logic [15:0] since_q;

	initial begin
		{last_q, done_q, since_q, period, first_hi} = '0;
	end

	// Edge to edge spacing; first high run after clr
	always @(posedge aclk) begin
		last_q <= pin;
		since_q <= (pin && !last_q) ? 16'h1 : since_q + 16'h1;
		if (pin && !last_q) period <= since_q;
		if (clr) begin
			first_hi <= 16'h0;
			done_q <= 1'b0;
		end else if (pin && !done_q) first_hi <= first_hi + 16'h1;
		else if (first_hi != 16'h0) done_q <= 1'b1;
	end
endmodule

// ==== tb/pdc_stage_asserts.sv ====
// Handshake timing checks on the stage's register slave.
// Assumes the master offers write address and data together.
`timescale 1ns/10ps
module pdc_stage_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late b");
	a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=>
		!s_axi_awready [*2]) else $error("aw reopened early");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	a_w_reopen: assert property (s_axi_bvalid && s_axi_bready |=>
		s_axi_awready && s_axi_wready)
		else $error("write ready slip");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("late r");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("r dropped");
	a_ar_reopen: assert property (s_axi_rvalid && s_axi_rready |=>
		s_axi_arready) else $error("ar ready slip");
	a_err_data: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |->
		s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("bad err");
endmodule

bind pdc_stage pdc_stage_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ==== tb/testbench.sv ====
// Self-checking bench for the dead-time and carrier stage.
// Assumes registered slave outputs; gate model on stage_out_b.
`timescale 1ns/10ps
module testbench;
	logic        aclk, aresetn, awv, wv, bry, arv, rry, dn, tclk, oa;
	logic        awr, wrr, bv, arr, rv, sa, sb, clr, aw, w, eb;
	logic [11:0] awa, ara;
	logic [31:0] wd, rdt;
	logic [1:0]  br, rr;
	logic [6:0]  evs;
	logic [15:0] per, fh, rising_edge_delay, fed, v;
	logic [33:0] q[$];
	int          errors, tests_run;
	int          na, nb;
	int          mev[4] = '{0, 1, 6, 0};

	pdc_stage dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .counter_zero_event(evs[0]),
		.counter_period_event(evs[1]), .compare_a_event(evs[2]),
		.compare_b_event(evs[3]), .trigger0_event(evs[4]),
		.trigger1_event(evs[5]), .count_down(dn), .sync_event(evs[6]),
		.timer_clock(tclk), .operator_out_a(oa), .stage_out_a(sa),
		.stage_out_b(sb));
	pdc_gate_model gate (.aclk(aclk), .pin(sb), .clr(clr), .period(per),
		.first_hi(fh));

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	initial begin
		tclk = 1'b0;
		forever #21 tclk = ~tclk;
	end

	task cmp(input logic [33:0] e, input logic [33:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("Error t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task summarize;
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Both channels offered at once, released each as taken
	task wr(input logic [11:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		{awv, wv, bry} <= 3'h7;
		{aw, w} = 2'h3;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && awr) {aw, awv} <= 2'h0;
			if (w && wrr) {w, wv} <= 2'h0;
		end
		do @(posedge aclk); while (!bv);
		cmp({32'h0, (a < 12'h0c0 || a > 12'h0d4) ? 2'h2 : 2'h0},
			{32'h0, br});
		bry <= 1'b0;
		@(posedge aclk);
	endtask
	task rd(input logic [11:0] a, input logic [33:0] e);
		q.push_back(e);
		ara <= a;
		{arv, rry} <= 2'h3;
		do @(posedge aclk); while (!arr);
		arv <= 1'b0;
		do @(posedge aclk); while (!rv);
		rry <= 1'b0;
		@(posedge aclk);
	endtask
	// Cycles from A rising to each output rising, seen mid-cycle
	task meas(output int a_n, output int b_n);
		a_n = 0;
		b_n = 0;
		oa <= 1'b1;
		for (int n = 1; n < 300 && !(a_n && b_n); n++) begin
			@(negedge aclk);
			if (sa && a_n == 0) a_n = n;
			if (sb && b_n == 0) b_n = n;
		end
		@(posedge aclk);
		oa <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask
	task pulse(input int i);
		@(posedge aclk);
		evs <= 7'h1 << i;
		@(posedge aclk);
		evs <= 7'h0;
	endtask

	always @(posedge aclk) begin
		if (rv && rry) cmp(q.pop_front(), {rr, rdt});
	end
	// Full run is under a thousand cycles
	initial begin
		#200000;
		errors++;
		summarize();
	end

	initial begin
		{aresetn, awv, wv, bry, arv, rry, dn, oa, clr} = '0;
		{awa, ara, wd, evs, rising_edge_delay, fed} = '0;
		errors = 0;
		tests_run = 0;
		void'($urandom(7243));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(12'h0c8, 34'h0_0001_8000);
		rd(12'h0cc, 34'h0);
		rd(12'h0d0, 34'h0);
		rd(12'h0d4, 34'h0);
		rd(12'h100, {2'h2, 32'h0});
		wr(12'h100, 32'hffff_ffff);
		$display("test reset done");
		// Wrong moment first, then the chosen one
		for (int i = 0; i < 3; i++) begin
			wr(12'h0c8, 32'h0001_8000 | (32'h10 << i));
			v = 16'($urandom);
			wr(12'h0d0, {16'h0, v});
			pulse(mev[i + 1]);
			rd(12'h0c0, {2'h0, fed, rising_edge_delay});
			pulse(mev[i]);
			rising_edge_delay = v;
			rd(12'h0c0, {2'h0, fed, rising_edge_delay});
		end
		wr(12'h0c8, 32'h0001_8088);
		v = 16'($urandom);
		wr(12'h0cc, {16'h0, v});
		for (int i = 0; i < 7; i++) pulse(i);
		rd(12'h0c0, {2'h0, fed, rising_edge_delay});
		wr(12'h0c8, 32'h0001_8080);
		fed = v;
		rd(12'h0c0, {2'h0, fed, rising_edge_delay});
		$display("test delays done");
		// Bypass off: separate paths, then dual-edge B, then timer ticks
		v = 16'(2 + $urandom % 6);
		wr(12'h0c8, 32'h0);
		wr(12'h0cc, 32'h2);
		wr(12'h0d0, {16'h0, v});
		meas(na, nb);
		cmp(34'(v + 3), 34'(na));
		cmp(34'h3, 34'(nb));
		wr(12'h0c8, 32'h100);
		meas(na, nb);
		cmp(34'h2, 34'(na));
		cmp(34'(v + 3), 34'(nb));
		wr(12'h0c8, 32'h2_0000);
		meas(na, nb);
		cmp(34'h1, {33'h0, na > v + 3 && na <= 6 * v + 8});
		$display("test paths done");
		wr(12'h0c8, 32'h0001_8000);
		eb = 1'b0;
		for (int f = 0; f < 12; f++) begin
			wr(12'h0c4, 32'(f % 4) << (2 * f));
			dn <= (f > 5);
			pulse(f % 6);
			repeat (4) @(posedge aclk);
			eb = (f % 4 == 0) ? eb : (f % 4 == 3) ? !eb : (f % 4 == 2);
			cmp({33'h0, eb}, {33'h0, sb});
		end
		$display("test actions done");
		dn <= 1'b0;
		oa <= 1'($urandom);
		wr(12'h0c4, 32'h2);
		pulse(0);
		for (int k = 0; k < 4; k++) begin
			wr(12'h0d4, 32'(k) << 12);
			repeat (5) @(posedge aclk);
			cmp({32'h0, oa ^ k[0] ^ k[1], !(k[0] ^ k[1])},
				{32'h0, sa, sb});
		end
		wr(12'h0d4, 32'h0);
		wr(12'h0c4, 32'h1);
		pulse(0);
		wr(12'h0d4, 32'h0000_0283);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		wr(12'h0c4, 32'h2);
		pulse(0);
		repeat (200) @(posedge aclk);
		cmp(34'd16, {18'h0, per});
		cmp(34'h1, {33'h0, fh > 16'd16 && fh <= 16'd32});
		$display("test carrier done");
		summarize();
	end
endmodule
